// >>> pkg/field_sensor_autorange_consts.svh
/*
  Offsets, fields, reset values, thresholds and timing of the range
  controller. Assumes pkg/ on the include path.
*/
`ifndef FIELD_SENSOR_AUTORANGE_CONSTS_SVH
`define FIELD_SENSOR_AUTORANGE_CONSTS_SVH

// ****************************************
// Sample and range figures
// ****************************************
`define FSA_ADC_W         12
`define FSA_RANGE_W       3
`define FSA_RANGE_MAX     3'h7
`define FSA_RANGE_MIN     3'h0
`define FSA_THR_HIGH      12'h700
`define FSA_THR_LOW       12'h100
`define FSA_AXES          3
`define FSA_CHANS         6

// ****************************************
// Register map
// ****************************************
`define FSA_REG_CTRL      4'h0
`define FSA_REG_RCMD      4'h4
`define FSA_REG_CAL       4'h8
`define FSA_REG_STAT      4'hc
`define FSA_CTRL_MODE_LSB 0
`define FSA_CTRL_RATE_LSB 2
`define FSA_CTRL_ROLEA    4
`define FSA_CTRL_ROLEB    5
`define FSA_CTRL_AUTO     6
`define FSA_CTRL_FLIP     7
`define FSA_CTRL_RST      8'h65
`define FSA_RCMD_SENSB    3
`define FSA_RCMD_REL      4
`define FSA_CAL_START     0

// ****************************************
// Timing
// ****************************************
`define FSA_CLK_HZ        250000000
`define FSA_VEC_HZ        24
`define FSA_DRIVE_HZ      15000
`define FSA_RATE_SEL0     2
`define FSA_RATE_SEL1     3
`define FSA_RATE_SEL2     4
`define FSA_RATE_SEL3     6
`define FSA_CAL_VECTORS   24

`endif

// >>> pkg/field_sensor_autorange_pkg.sv
/*
  Types of the range controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package field_sensor_autorange_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_START = 2'b01,
    SEQ_WAIT  = 2'b10
  } seq_state_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_CURR = 2'b01,
    CAL_FLIP = 2'b10
  } cal_state_t;

  typedef enum logic [1:0] {
    TM_RSVD   = 2'b00,
    TM_NORMAL = 2'b01,
    TM_HIGH   = 2'b10,
    TM_ENH    = 2'b11
  } tm_mode_t;

  typedef enum logic {
    ROLE_PRI = 1'b0,
    ROLE_SEC = 1'b1
  } role_t;

endpackage

// >>> rtl/range_stepper.sv
/*
  Range state of one triaxial sensor.
  Assumes axis-ordered samples, last flagged, and i_apply at the slot.
*/
`timescale 1ns/1ns
`include "field_sensor_autorange_consts.svh"

module range_stepper (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  // Raw samples
  input  wire logic                    i_smp_valid,
  input  wire logic [`FSA_ADC_W-1:0]   i_smp_data,
  input  wire logic                    i_smp_last,
  // Control
  input  wire logic                    i_apply,
  input  wire logic                    i_auto_en,
  input  wire logic                    i_cmd_valid,
  input  wire logic [`FSA_RANGE_W-1:0] i_cmd_range,
  input  wire logic                    i_cmd_release,
  // State
  output logic      [`FSA_RANGE_W-1:0] o_range,
  output logic                         o_hold
);

  logic [`FSA_ADC_W-1:0]   mag;
  logic                    over_q, over_d, under_q, under_d;
  logic                    up_q, up_d, dn_q, dn_d;
  logic                    cmd_q, cmd_d, hold_d;
  logic [`FSA_RANGE_W-1:0] cmd_rng_q, cmd_rng_d, range_d;
  logic                    acc_over, acc_under, end_vec;

  always_comb begin
    // Two's complement magnitude; -2048 reads as 2048 unsigned
    mag = i_smp_data[`FSA_ADC_W-1] ? (~i_smp_data + 12'h001) : i_smp_data;
    acc_over  = over_q | (mag > `FSA_THR_HIGH);
    acc_under = under_q & (mag < `FSA_THR_LOW);
    end_vec   = i_smp_valid & i_smp_last;
    over_d    = over_q;
    under_d   = under_q;
    up_d      = i_apply ? 1'b0 : up_q;
    dn_d      = i_apply ? 1'b0 : dn_q;
    if (i_smp_valid) begin
      over_d  = end_vec ? 1'b0 : acc_over;
      under_d = end_vec ? 1'b1 : acc_under;
    end
    // A decision landing in the apply cycle survives
    if (end_vec) begin
      up_d = up_d | acc_over;
      dn_d = acc_under;
    end
    cmd_d     = i_apply ? 1'b0 : cmd_q;
    cmd_rng_d = cmd_rng_q;
    hold_d    = o_hold;
    range_d   = o_range;
    // Release first so a hold set at the slot wins
    if (i_cmd_release) begin
      hold_d = 1'b0;
      cmd_d  = 1'b0;
    end
    if (i_apply) begin
      if (cmd_q) begin
        range_d = cmd_rng_q;
        hold_d  = 1'b1;
      end else if (!o_hold && i_auto_en) begin
        if (up_q && o_range != `FSA_RANGE_MAX) begin
          range_d = o_range + 3'h1;
        end else if (!up_q && dn_q && o_range != `FSA_RANGE_MIN) begin
          range_d = o_range - 3'h1;
        end
      end
    end
    if (i_cmd_valid) begin
      cmd_d     = 1'b1;
      cmd_rng_d = i_cmd_range;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      over_q    <= 1'b0;
      under_q   <= 1'b1;
      up_q      <= 1'b0;
      dn_q      <= 1'b0;
      cmd_q     <= 1'b0;
      cmd_rng_q <= `FSA_RANGE_MAX;
      o_hold    <= 1'b0;
      o_range   <= `FSA_RANGE_MAX;
    end else begin
      over_q    <= over_d;
      under_q   <= under_d;
      up_q      <= up_d;
      dn_q      <= dn_d;
      cmd_q     <= cmd_d;
      cmd_rng_q <= cmd_rng_d;
      o_hold    <= hold_d;
      o_range   <= range_d;
    end
  end

endmodule

// >>> rtl/field_sensor_autorange.sv
/*
  Acquisition and range control for twin triaxial field sensors.
  Assumes a 12-bit converter with start/done and frame slot ticks.
*/
// Contract
// - Eight ranges per sensor, each four times the span of the last.
// - Every axis is converted to a 12-bit sample before range decisions.
// - Any axis above seven eighths of full scale steps the sensor up.
// - All axes below one eighth of full scale step the sensor down.
// - Range changes apply only at a fixed slot in the frame.
// - Decisions use raw samples at the basic sampling rate.
// - Sensor drive is 15 kHz divided from the master clock.
// - Commands give each sensor primary or secondary stream role.
// - Vectors at 24 per second, standard stream at 2, 3, 4 or 6.
// - Calibration switches known currents, then inverts signal phase.
// - After reset the telemetry mode is the equal rate mode.
`timescale 1ns/1ns
`include "field_sensor_autorange_consts.svh"

module field_sensor_autorange #(
  parameter int VEC_CYC   = `FSA_CLK_HZ / `FSA_VEC_HZ,
  parameter int DRV_HALF  = `FSA_CLK_HZ / (2 * `FSA_DRIVE_HZ),
  parameter int CAL_VECS  = `FSA_CAL_VECTORS,
  parameter int RANGE_SLOT = 0
) (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  // Register port
  input  wire logic [3:0]              i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [31:0]             o_rdata,
  // Converter
  output logic                         o_adc_start,
  output logic      [2:0]              o_adc_chan,
  input  wire logic                    i_adc_done,
  input  wire logic [`FSA_ADC_W-1:0]   i_adc_data,
  // Telemetry timing
  input  wire logic                    i_frame_sync,
  input  wire logic                    i_slot_tick,
  // Sensor control
  output logic      [`FSA_RANGE_W-1:0] o_range_a,
  output logic      [`FSA_RANGE_W-1:0] o_range_b,
  output logic                         o_drive,
  output logic                         o_cal_on,
  output logic                         o_flip,
  // Snapshot stream
  output logic                         o_snap_valid,
  output logic      [35:0]             o_snap_vec,
  output logic      [`FSA_RANGE_W-1:0] o_snap_range,
  // Primary and secondary streams
  output logic                         o_pri_valid,
  output logic      [35:0]             o_pri_vec,
  output logic      [`FSA_RANGE_W-1:0] o_pri_range,
  output logic                         o_pri_is_b,
  output logic                         o_sec_valid,
  output logic      [35:0]             o_sec_vec,
  output logic      [`FSA_RANGE_W-1:0] o_sec_range
);

  localparam int TICK_W = $clog2(VEC_CYC + 1);
  localparam int DRV_W  = $clog2(DRV_HALF + 1);
  localparam logic [3:0] DIV0 = 4'(`FSA_VEC_HZ / `FSA_RATE_SEL0);
  localparam logic [3:0] DIV1 = 4'(`FSA_VEC_HZ / `FSA_RATE_SEL1);
  localparam logic [3:0] DIV2 = 4'(`FSA_VEC_HZ / `FSA_RATE_SEL2);
  localparam logic [3:0] DIV3 = 4'(`FSA_VEC_HZ / `FSA_RATE_SEL3);

  // ****************************************
  // Register port
  // ****************************************
  logic [7:0]  ctrl_q, ctrl_d;
  logic [31:0] rdata_d;
  logic        wr_rcmd, cal_go;
  logic [1:0]  cmd_valid, hold;
  logic        cal_busy;
  field_sensor_autorange_pkg::tm_mode_t mode;
  field_sensor_autorange_pkg::role_t    role_a, role_b;

  always_comb begin
    ctrl_d  = ctrl_q;
    rdata_d = 32'h0000_0000;
    wr_rcmd = i_wr && i_addr == `FSA_REG_RCMD;
    cal_go  = i_wr && i_addr == `FSA_REG_CAL && i_wdata[`FSA_CAL_START];
    if (i_wr && i_addr == `FSA_REG_CTRL) begin
      ctrl_d = i_wdata[7:0];
    end
    if (i_rd) begin
      case (i_addr)
        `FSA_REG_CTRL: rdata_d = {24'h00_0000, ctrl_q};
        `FSA_REG_CAL:  rdata_d = {31'h0000_0000, cal_busy};
        `FSA_REG_STAT: rdata_d = {20'h0_0000, o_flip, o_cal_on, hold,
                                  1'b0, o_range_b, 1'b0, o_range_a};
        default:       rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q  <= `FSA_CTRL_RST;
      o_rdata <= 32'h0000_0000;
    end else begin
      ctrl_q  <= ctrl_d;
      o_rdata <= rdata_d;
    end
  end

  assign mode   = field_sensor_autorange_pkg::tm_mode_t'(
                    ctrl_q[`FSA_CTRL_MODE_LSB +: 2]);
  assign role_a = field_sensor_autorange_pkg::role_t'(
                    ctrl_q[`FSA_CTRL_ROLEA]);
  assign role_b = field_sensor_autorange_pkg::role_t'(
                    ctrl_q[`FSA_CTRL_ROLEB]);
  assign cmd_valid[0] = wr_rcmd && !i_wdata[`FSA_RCMD_SENSB]
                        && !i_wdata[`FSA_RCMD_REL];
  assign cmd_valid[1] = wr_rcmd && i_wdata[`FSA_RCMD_SENSB]
                        && !i_wdata[`FSA_RCMD_REL];

  // ****************************************
  // Sample tick and converter sequencer
  // ****************************************
  // Ticks during a busy vector are dropped; six conversions fit easily
  logic [TICK_W-1:0] tick_q, tick_d;
  logic              tick;
  field_sensor_autorange_pkg::seq_state_t seq_q, seq_d;
  logic [2:0]        chan_d;
  logic [`FSA_ADC_W-1:0] vec_q [`FSA_CHANS];
  logic [`FSA_ADC_W-1:0] vec_d [`FSA_CHANS];
  logic              vdone_q, vdone_d, smp_ok;

  always_comb begin
    tick    = tick_q == TICK_W'(VEC_CYC - 1);
    tick_d  = tick ? '0 : tick_q + 1'b1;
    seq_d   = seq_q;
    chan_d  = o_adc_chan;
    vec_d   = vec_q;
    vdone_d = 1'b0;
    smp_ok  = seq_q == field_sensor_autorange_pkg::SEQ_WAIT && i_adc_done;
    case (seq_q)
      field_sensor_autorange_pkg::SEQ_IDLE: begin
        if (tick) begin
          seq_d  = field_sensor_autorange_pkg::SEQ_START;
          chan_d = 3'h0;
        end
      end
      field_sensor_autorange_pkg::SEQ_START: begin
        seq_d = field_sensor_autorange_pkg::SEQ_WAIT;
      end
      field_sensor_autorange_pkg::SEQ_WAIT: begin
        if (i_adc_done) begin
          vec_d[o_adc_chan] = i_adc_data;
          if (o_adc_chan == 3'(`FSA_CHANS - 1)) begin
            seq_d   = field_sensor_autorange_pkg::SEQ_IDLE;
            vdone_d = 1'b1;
          end else begin
            seq_d  = field_sensor_autorange_pkg::SEQ_START;
            chan_d = o_adc_chan + 3'h1;
          end
        end
      end
      default: seq_d = field_sensor_autorange_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tick_q      <= '0;
      seq_q       <= field_sensor_autorange_pkg::SEQ_IDLE;
      o_adc_chan  <= 3'h0;
      o_adc_start <= 1'b0;
      vdone_q     <= 1'b0;
      for (int i = 0; i < `FSA_CHANS; i++) begin
        vec_q[i] <= 12'h000;
      end
    end else begin
      tick_q      <= tick_d;
      seq_q       <= seq_d;
      o_adc_chan  <= chan_d;
      o_adc_start <= seq_d == field_sensor_autorange_pkg::SEQ_START;
      vdone_q     <= vdone_d;
      vec_q       <= vec_d;
    end
  end

  // ****************************************
  // Range control per sensor
  // ****************************************
  logic [7:0] slot_q, slot_d;
  logic       apply;
  logic [`FSA_RANGE_W-1:0] rng [2];

  always_comb begin
    slot_d = slot_q;
    if (i_frame_sync) begin
      slot_d = 8'h00;
    end else if (i_slot_tick) begin
      slot_d = slot_q + 8'h01;
    end
    apply = i_slot_tick && !i_frame_sync
            && slot_q == 8'(RANGE_SLOT);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      slot_q <= 8'h00;
    end else begin
      slot_q <= slot_d;
    end
  end

  for (genvar s = 0; s < 2; s++) begin : g_sensor
    range_stepper u_step (
      .i_clk         (i_clk),
      .i_sys_rst     (i_sys_rst),
      .i_smp_valid   (smp_ok && (o_adc_chan >= 3'(s * `FSA_AXES))
                      && (o_adc_chan < 3'((s + 1) * `FSA_AXES))),
      .i_smp_data    (i_adc_data),
      .i_smp_last    (o_adc_chan == 3'((s + 1) * `FSA_AXES - 1)),
      .i_apply       (apply),
      .i_auto_en     (ctrl_q[`FSA_CTRL_AUTO]),
      .i_cmd_valid   (cmd_valid[s]),
      .i_cmd_range   (i_wdata[2:0]),
      .i_cmd_release (wr_rcmd && i_wdata[`FSA_RCMD_REL]
                      && i_wdata[`FSA_RCMD_SENSB] == 1'(s)),
      .o_range       (rng[s]),
      .o_hold        (hold[s])
    );
  end
  assign o_range_a = rng[0];
  assign o_range_b = rng[1];

  // ****************************************
  // Stream routing and decimation
  // ****************************************
  logic [3:0]  dec_q, dec_d, div;
  logic        half_q, half_d, pri_b;
  logic [35:0] vec_a, vec_b;
  logic        snap_v_d, pri_v_d, sec_v_d;

  always_comb begin
    vec_a = {vec_q[2], vec_q[1], vec_q[0]};
    vec_b = {vec_q[5], vec_q[4], vec_q[3]};
    // Both claiming one role: sensor A keeps primary
    pri_b = role_a == field_sensor_autorange_pkg::ROLE_SEC
            && role_b == field_sensor_autorange_pkg::ROLE_PRI;
    case (ctrl_q[`FSA_CTRL_RATE_LSB +: 2])
      2'h0:    div = DIV0;
      2'h1:    div = DIV1;
      2'h2:    div = DIV2;
      default: div = DIV3;
    endcase
    dec_d    = dec_q;
    half_d   = half_q;
    snap_v_d = vdone_q;
    pri_v_d  = 1'b0;
    sec_v_d  = 1'b0;
    if (vdone_q) begin
      if (dec_q + 4'h1 >= div) begin
        dec_d   = 4'h0;
        pri_v_d = 1'b1;
        half_d  = !half_q;
        case (mode)
          field_sensor_autorange_pkg::TM_HIGH: sec_v_d = !half_q;
          field_sensor_autorange_pkg::TM_ENH:  sec_v_d = 1'b0;
          default:                             sec_v_d = 1'b1;
        endcase
      end else begin
        dec_d = dec_q + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dec_q        <= 4'h0;
      half_q       <= 1'b0;
      o_snap_valid <= 1'b0;
      o_snap_vec   <= '0;
      o_snap_range <= '0;
      o_pri_valid  <= 1'b0;
      o_pri_vec    <= '0;
      o_pri_range  <= '0;
      o_pri_is_b   <= 1'b0;
      o_sec_valid  <= 1'b0;
      o_sec_vec    <= '0;
      o_sec_range  <= '0;
    end else begin
      dec_q        <= dec_d;
      half_q       <= half_d;
      o_snap_valid <= snap_v_d;
      o_pri_valid  <= pri_v_d;
      o_sec_valid  <= sec_v_d;
      o_pri_is_b   <= pri_b;
      if (vdone_q) begin
        o_snap_vec   <= pri_b ? vec_b : vec_a;
        o_snap_range <= pri_b ? rng[1] : rng[0];
        o_pri_vec    <= pri_b ? vec_b : vec_a;
        o_pri_range  <= pri_b ? rng[1] : rng[0];
        o_sec_vec    <= pri_b ? vec_a : vec_b;
        o_sec_range  <= pri_b ? rng[0] : rng[1];
      end
    end
  end

  // ****************************************
  // Sensor drive and calibration
  // ****************************************
  logic [DRV_W-1:0] drv_q, drv_d;
  logic             drive_d;
  field_sensor_autorange_pkg::cal_state_t cal_q, cal_d;
  logic [7:0]       calc_q, calc_d;
  logic             cal_on_d, flip_d, cal_last;

  always_comb begin
    drive_d = o_drive;
    drv_d   = drv_q + 1'b1;
    if (drv_q == DRV_W'(DRV_HALF - 1)) begin
      drv_d   = '0;
      drive_d = !o_drive;
    end
    cal_d    = cal_q;
    calc_d   = calc_q;
    cal_last = calc_q == 8'(CAL_VECS - 1);
    case (cal_q)
      field_sensor_autorange_pkg::CAL_IDLE: begin
        calc_d = 8'h00;
        if (cal_go) begin
          cal_d = field_sensor_autorange_pkg::CAL_CURR;
        end
      end
      field_sensor_autorange_pkg::CAL_CURR: begin
        if (vdone_q) begin
          calc_d = cal_last ? 8'h00 : calc_q + 8'h01;
          if (cal_last) begin
            cal_d = field_sensor_autorange_pkg::CAL_FLIP;
          end
        end
      end
      field_sensor_autorange_pkg::CAL_FLIP: begin
        if (vdone_q) begin
          calc_d = cal_last ? 8'h00 : calc_q + 8'h01;
          if (cal_last) begin
            cal_d = field_sensor_autorange_pkg::CAL_IDLE;
          end
        end
      end
      default: cal_d = field_sensor_autorange_pkg::CAL_IDLE;
    endcase
    cal_busy = cal_q != field_sensor_autorange_pkg::CAL_IDLE;
    cal_on_d = cal_d == field_sensor_autorange_pkg::CAL_CURR;
    flip_d   = cal_d == field_sensor_autorange_pkg::CAL_FLIP
               || ctrl_d[`FSA_CTRL_FLIP];
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      drv_q    <= '0;
      o_drive  <= 1'b0;
      cal_q    <= field_sensor_autorange_pkg::CAL_IDLE;
      calc_q   <= 8'h00;
      o_cal_on <= 1'b0;
      o_flip   <= 1'b0;
    end else begin
      drv_q    <= drv_d;
      o_drive  <= drive_d;
      cal_q    <= cal_d;
      calc_q   <= calc_d;
      o_cal_on <= cal_on_d;
      o_flip   <= flip_d;
    end
  end

endmodule

// >>> dv/fsa_props.sv
/*
  Port checker of the field sensor range controller.
  Assumes a bind into the top module and a single clock.
*/
`timescale 1ns/1ns
`include "field_sensor_autorange_consts.svh"

module fsa_props #(
  parameter int DRV_HALF   = 8,
  parameter int RANGE_SLOT = 0
) (
  // Clock, reset, register port
  input wire logic                    i_clk,
  input wire logic                    i_sys_rst,
  input wire logic [3:0]              i_addr,
  input wire logic [31:0]             i_wdata,
  input wire logic                    i_wr,
  input wire logic                    i_rd,
  input wire logic [31:0]             o_rdata,
  // Converter and timing
  input wire logic                    o_adc_start,
  input wire logic [2:0]              o_adc_chan,
  input wire logic                    i_frame_sync,
  input wire logic                    i_slot_tick,
  // Sensor control and streams
  input wire logic [`FSA_RANGE_W-1:0] o_range_a,
  input wire logic [`FSA_RANGE_W-1:0] o_range_b,
  input wire logic                    o_drive,
  input wire logic                    o_cal_on,
  input wire logic                    o_flip,
  input wire logic                    o_snap_valid,
  input wire logic                    o_pri_is_b
);
  logic [7:0] slot_q, slot_d;
  logic [2:0] chan_q, chan_d;
  logic       drv_q, seen_q, seen_d, cmd_q, cmd_d, apply;
  int         cnt_q, cnt_d;

  always_comb begin
    apply = i_slot_tick && !i_frame_sync && slot_q == 8'(RANGE_SLOT);
    slot_d = i_frame_sync ? 8'h0 : slot_q + 8'(i_slot_tick);
    chan_d = o_adc_start ? o_adc_chan : chan_q;
    seen_d = seen_q || (o_drive != drv_q);
    cnt_d = (o_drive != drv_q) ? 0 : cnt_q + 1;
    cmd_d = cmd_q || (i_wr && i_addr == `FSA_REG_RCMD);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      slot_q <= 8'h0;
      chan_q <= 3'h0;
      drv_q <= 1'b0;
      seen_q <= 1'b0;
      cnt_q <= 0;
      cmd_q <= 1'b0;
    end else begin
      slot_q <= slot_d;
      chan_q <= chan_d;
      drv_q <= o_drive;
      seen_q <= seen_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("rdata idle");
  range_slot_a: assert property (
    (o_range_a != $past(o_range_a) || o_range_b != $past(o_range_b))
    |-> $past(apply)) else $error("off slot");
  range_step_a: assert property (
    $past(apply) && !cmd_q |-> o_range_a == $past(o_range_a) ||
    (o_range_a == $past(o_range_a) + 3'h1 && $past(o_range_a) != 3'h7) ||
    (o_range_a + 3'h1 == $past(o_range_a) && $past(o_range_a) != 3'h0))
    else $error("bad range step");
  adc_pulse_a: assert property (
    o_adc_start |=> !o_adc_start && $stable(o_adc_chan))
    else $error("start pulse");
  chan_order_a: assert property (
    o_adc_start |-> o_adc_chan <= 3'h5 &&
    (o_adc_chan == 3'h0 || o_adc_chan == chan_q + 3'h1))
    else $error("chan order");
  drive_half_a: assert property (
    (o_drive != drv_q) && seen_q |-> cnt_q == DRV_HALF - 1)
    else $error("drive half");
  cal_start_a: assert property (
    i_wr && i_addr == `FSA_REG_CAL && i_wdata[0] && !o_cal_on && !o_flip
    |=> o_cal_on) else $error("cal start");
  flip_after_a: assert property ($fell(o_cal_on) |-> o_flip)
    else $error("no flip");
  role_map_a: assert property (
    i_wr && i_addr == `FSA_REG_CTRL |-> ##2 o_pri_is_b ==
    ($past(i_wdata[`FSA_CTRL_ROLEA], 2) &&
     !$past(i_wdata[`FSA_CTRL_ROLEB], 2)))
    else $error("role");
  snap_pulse_a: assert property (
    o_snap_valid |=> !o_snap_valid [*8]) else $error("snap");
endmodule

bind field_sensor_autorange fsa_props #(
  .DRV_HALF(DRV_HALF), .RANGE_SLOT(RANGE_SLOT)
) u_props (.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .o_adc_start, .o_adc_chan, .i_frame_sync, .i_slot_tick, .o_range_a,
  .o_range_b, .o_drive, .o_cal_on, .o_flip, .o_snap_valid, .o_pri_is_b);

// >>> dv/adc_model.sv
/*
  Behavioural 12-bit converter in front of the controller.
  Assumes one done pulse per start after i_lat extra cycles.
*/
`timescale 1ns/1ns

module adc_model (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // Request and analog stand-ins
  input  wire logic             i_start,
  input  wire logic [2:0]       i_chan,
  input  wire logic [5:0][11:0] i_smp,
  input  wire logic [3:0]       i_lat,
  // Result
  output logic                  o_done,
  output logic      [11:0]      o_data
);
  logic [3:0] cnt_q;
  logic [2:0] chan_q;
  logic       busy_q;

  // Data toggles outside done so a stale sample never looks valid
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      chan_q <= 3'h0;
      o_done <= 1'b0;
      o_data <= 12'h0;
    end else begin
      o_done <= 1'b0;
      o_data <= ~o_data;
      if (i_start) begin
        busy_q <= 1'b1;
        chan_q <= i_chan;
        cnt_q <= i_lat;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        o_done <= 1'b1;
        o_data <= i_smp[chan_q];
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

// >>> dv/test_field_sensor_autorange.sv
/*
  Self-checking bench of the range controller.
  Assumes the converter model; frame timing is made here.
*/
`timescale 1ns/1ns
`include "field_sensor_autorange_consts.svh"

module test_field_sensor_autorange;
  logic             i_clk = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic             i_sys_rst = 1'b1, i_frame_sync = 1'b0, i_slot_tick = 1'b0;
  logic [3:0]       i_addr = 4'h0, lat = 4'h0;
  logic [31:0]      i_wdata = 32'h0, o_rdata;
  logic [5:0][11:0] smp = '0;
  logic             o_adc_start, adc_done, o_snap_valid, o_cal_on;
  logic             o_flip, o_pri_is_b, flipped;
  logic [2:0]       o_adc_chan, o_range_a, o_range_b, o_snap_range;
  logic [2:0]       ea = 3'h7, eb = 3'h7;
  logic [11:0]      adc_data;
  logic [35:0]      o_snap_vec;
  int               ca, cb, k, n_errors = 0, comparisons = 0, cyc = 0;

  always #2 i_clk = ~i_clk;

  field_sensor_autorange #(.VEC_CYC(200), .DRV_HALF(8), .CAL_VECS(2),
    .RANGE_SLOT(0)) dut (.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_adc_start, .o_adc_chan, .i_adc_done(adc_done),
    .i_adc_data(adc_data), .i_frame_sync, .i_slot_tick, .o_range_a,
    .o_range_b, .o_drive(), .o_cal_on, .o_flip, .o_snap_valid, .o_snap_vec,
    .o_snap_range, .o_pri_valid(), .o_pri_vec(), .o_pri_range(), .o_pri_is_b,
    .o_sec_valid(), .o_sec_vec(), .o_sec_range());

  adc_model partner (.i_clk, .i_sys_rst, .i_start(o_adc_start),
    .i_chan(o_adc_chan), .i_smp(smp), .i_lat(lat), .o_done(adc_done),
    .o_data(adc_data));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk) begin i_wr <= 1'b1; i_addr <= a; i_wdata <= d; end
    @(posedge i_clk) i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk) begin i_rd <= 1'b1; i_addr <= a; end
    @(posedge i_clk) i_rd <= 1'b0;
    @(negedge i_clk) check(o_rdata, e);
  endtask

  // Class 0 small, 1 mid, 2 one axis over 7/8; 8 up: small, range c-8
  function automatic logic [11:0] gen(input int c);
    logic [11:0] m;
    m = c == 2 ? 12'h701 + 12'($urandom % 32'hff) : c == 1 ?
      12'h100 + 12'($urandom % 32'h601) : 12'($urandom % 32'h100);
    return ($urandom % 2) ? -m : m;
  endfunction

  function automatic logic [2:0] nxt(input logic [2:0] r, input int c);
    if (c > 2) return 3'(c - 8);
    if (c == 2) return r == 3'h7 ? r : r + 3'h1;
    if (c == 0) return r == 3'h0 ? r : r - 3'h1;
    return r;
  endfunction

  task automatic fill(input int a_c, input int b_c);
    int big, c;
    big = $urandom % 3;
    ca = a_c;
    cb = b_c;
    @(posedge i_clk) lat <= ($urandom % 4 == 0) ? 4'hc : 4'($urandom % 3);
    for (int s = 0; s < 6; s++) begin
      c = s < 3 ? a_c : b_c;
      if (c == 2 && s % 3 != big) c = $urandom % 2;
      smp[s] <= gen(c);
    end
  endtask

  // One vector, then slot 0 (apply) and slot 1 (no apply) of a frame
  task automatic step();
    k = 0;
    do @(negedge i_clk); while (o_snap_valid !== 1'b1 && k++ < 400);
    check({o_snap_range, o_snap_vec}, {ea, smp[2], smp[1], smp[0]});
    ea = nxt(ea, ca);
    eb = nxt(eb, cb);
    @(posedge i_clk) i_frame_sync <= 1'b1;
    @(posedge i_clk) begin i_frame_sync <= 1'b0; i_slot_tick <= 1'b1; end
    @(posedge i_clk);
    @(posedge i_clk) i_slot_tick <= 1'b0;
    @(negedge i_clk);
    check(o_range_a, ea);
    check(o_range_b, eb);
  endtask

  task automatic give_verdict();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      give_verdict();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(62136));
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    fill(0, 2);
    rd(`FSA_REG_CTRL, 32'(`FSA_CTRL_RST));
    rd(`FSA_REG_STAT, 32'h77);
    rd(4'h2, 32'h0);
    for (int i = 1; i <= 40; i++) begin
      step();
      fill(i < 8 ? 0 : i < 16 ? 2 : $urandom % 3,
        i < 8 ? 2 : i < 16 ? 0 : $urandom % 3);
    end
    wr(`FSA_REG_RCMD, 32'h3);
    wr(`FSA_REG_RCMD, 32'hd);
    fill(11, 13);
    step();
    fill(11, 13);
    step();
    wr(`FSA_REG_RCMD, 32'h10);
    wr(`FSA_REG_RCMD, 32'h18);
    fill(1, 1);
    step();
    fill(0, 0);
    step();
    for (int r = 0; r < 4; r++) begin
      wr(`FSA_REG_CTRL, 32'h45 | (r << 4));
      repeat (2) @(negedge i_clk);
      check(o_pri_is_b, r == 1);
    end
    wr(`FSA_REG_CTRL, `FSA_CTRL_RST);
    wr(`FSA_REG_CAL, 32'h1);
    @(negedge i_clk);
    check(o_cal_on, 1'b1);
    rd(`FSA_REG_CAL, 32'h1);
    k = 0;
    flipped = 1'b0;
    while ((o_cal_on || o_flip) && k++ < 3000) begin
      @(negedge i_clk);
      flipped |= o_flip;
    end
    check(flipped, 1'b1);
    check(o_cal_on | o_flip, 1'b0);
    give_verdict();
  end
endmodule
